// ===== core/acc_pkg.sv
/*
  constants for the acquisition chain conversion control: register indices,
  field positions, values after reset, sequencing counts.
  assumes nothing of its surroundings beyond a SystemVerilog package scope.
*/
`default_nettype none

package acc_pkg;

  // ----------------------------------------------------------------
  // register indices on the configuration port
  // ----------------------------------------------------------------
  localparam logic [3:0] IDX_CONV_CONTROL      = 4'h0;
  localparam logic [3:0] IDX_CHAIN_STAGE_EN    = 4'h1;
  localparam logic [3:0] IDX_RATE_MEDIUM       = 4'h2;
  localparam logic [3:0] IDX_COARSE_FINE_GAIN  = 4'h3;
  localparam logic [3:0] IDX_FINE_OFFSET       = 4'h4;
  localparam logic [3:0] IDX_CONV_STATUS       = 4'h5;
  localparam logic [3:0] IDX_BANDGAP_MODE      = 4'h6;
  localparam logic [3:0] IDX_RESULT_HI         = 4'h7;
  localparam logic [3:0] IDX_RESULT_LO         = 4'h8;

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int START_BIT        = 7;
  localparam int ELEM_CODE_HI     = 6;
  localparam int ELEM_CODE_LO     = 5;
  localparam int RATIO_CODE_HI    = 4;
  localparam int RATIO_CODE_LO    = 2;
  localparam int REPEAT_BIT       = 1;
  localparam int MOD_EN_BIT       = 0;
  localparam int COARSE_EN_BIT    = 1;
  localparam int MEDIUM_EN_BIT    = 2;
  localparam int FINE_EN_BIT      = 3;
  localparam int COARSE_GAIN_BIT  = 7;
  localparam int RATE_SEL_HI      = 7;
  localparam int RATE_SEL_LO      = 6;
  localparam int MED_GAIN_HI      = 5;
  localparam int MED_GAIN_LO      = 4;
  localparam int BUSY_BIT         = 7;
  localparam int LOAD_DEF_BIT     = 6;

  // ----------------------------------------------------------------
  // values after reset; load_defaults reloads all but the mux and bandgap mode
  // ----------------------------------------------------------------
  localparam logic [7:0] RST_CONV_CONTROL     = 8'h2a; // 2 elementary, ratio 32
  localparam logic [7:0] RST_CHAIN_STAGE_EN   = 8'h01; // amplifiers off, modulator on
  localparam logic [7:0] RST_RATE_MEDIUM      = 8'hc0; // fastest sampling
  localparam logic [7:0] RST_COARSE_FINE_GAIN = 8'h0c; // fine gain 12/12
  localparam logic [7:0] RST_FINE_OFFSET      = 8'h00;
  localparam logic [5:0] RST_MUX_SEL          = 6'h00;
  localparam logic [1:0] RST_BANDGAP_MODE     = 2'h0;

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  localparam logic [2:0]  INIT_CYCLES   = 3'h2;    // clk_sys cycles of setup
  localparam logic [10:0] RATIO_BASE    = 11'h008; // ratio for code 000
  localparam logic [6:0]  OSC_DIV_SLOW  = 7'h40;   // 4 MHz / 64 = 62.5 kHz
  localparam logic [3:0]  MEDIUM_OFS_MAX = 4'h5;

  // bandgap chopping modes
  localparam logic [1:0] BG_HIGH   = 2'h0;
  localparam logic [1:0] BG_LOW    = 2'h1;
  localparam logic [1:0] BG_TOGGLE = 2'h2;
  localparam logic [1:0] BG_HALF   = 2'h3;

endpackage : acc_pkg

`default_nettype wire

// ===== core/acc_tick_if.sv
/*
  carrier between the conversion controller and its sampling tick generator.
  assumes both ends run on clk_sys.
*/
`default_nettype none

interface acc_tick_if;
  logic [1:0] rate_sel; // over-sampling rate code
  logic       run;      // divider runs while high, held cleared otherwise
  logic       fs_tick;  // one clk_sys pulse per over-sampling period

  modport gen  (input rate_sel, input run, output fs_tick);
  modport user (output rate_sel, output run, input fs_tick);
endinterface : acc_tick_if

`default_nettype wire

// ===== core/acc_tick_gen.sv
/*
  over-sampling tick generator: brings the 4 MHz oscillator into clk_sys and
  divides it by 64, 32, 16 or 8.
  assumes the oscillator is far slower than clk_sys so every edge is seen.
*/
`default_nettype none

module acc_tick_gen (
  input  wire logic clk_sys,
  input  wire logic resetn,
  input  wire logic ce,
  input  wire logic osc_in,
  acc_tick_if.gen   tick
);

  logic       osc_meta;
  logic       osc_sync;
  logic       osc_last;
  logic [6:0] div_cnt;
  logic [6:0] div_len;
  logic       osc_rise;

  // ----------------------------------------------------------------
  // oscillator synchroniser
  // ----------------------------------------------------------------
  // second and third stages feed the edge detector, never the first
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      osc_meta <= 1'b0;
      osc_sync <= 1'b0;
      osc_last <= 1'b0;
    end else if (ce) begin
      osc_meta <= osc_in;
      osc_sync <= osc_meta;
      osc_last <= osc_sync;
    end
  end

  assign osc_rise = osc_sync & ~osc_last;

  // ----------------------------------------------------------------
  // divider
  // ----------------------------------------------------------------
  // rate code to divide ratio
  assign div_len = acc_pkg::OSC_DIV_SLOW >> tick.rate_sel;

  // held at zero while idle so the first period is a full one
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      div_cnt      <= 7'h00;
      tick.fs_tick <= 1'b0;
    end else if (ce) begin
      tick.fs_tick <= 1'b0;
      if (!tick.run) begin
        div_cnt <= 7'h00;
      end else if (osc_rise) begin
        if (div_cnt == div_len - 7'h01) begin
          div_cnt      <= 7'h00;
          tick.fs_tick <= 1'b1;
        end else begin
          div_cnt <= div_cnt + 7'h01;
        end
      end
    end
  end

endmodule // acc_tick_gen

`default_nettype wire

// ===== core/acc_ctrl.sv
/*
  acquisition chain conversion control: configuration registers, decode of
  stage enables, gains and offsets, and the conversion sequencer.
  assumes a byte-wide register port driven on clk_sys by the two-wire slave,
  an oscillator pin and a modulator bit from the analog side.
*/
`default_nettype none

module acc_ctrl (
  input  wire logic        clk_sys,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        reg_wr_en,
  input  wire logic        reg_rd_en,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [7:0]  reg_wdata,
  output logic      [7:0]  reg_rdata,
  input  wire logic        start_in,
  input  wire logic        osc_in,
  input  wire logic        mod_bit,
  output logic             busy,
  output logic             result_ready,
  output logic      [15:0] result,
  output logic             modulator_on,
  output logic             coarse_amp_stage,
  output logic             medium_amp_stage,
  output logic             fine_amp_stage,
  output logic             coarse_bypass,
  output logic             medium_bypass,
  output logic             fine_bypass,
  output logic      [3:0]  coarse_gain_sel,
  output logic      [3:0]  medium_gain_sel,
  output logic      [3:0]  medium_offset_sel,
  output logic      [6:0]  fine_gain_sel,
  output logic      [6:0]  fine_offset_sel,
  output logic             amp_chop,
  output logic             bandgap_chop,
  output logic      [1:0]  sample_rate_sel,
  output logic      [5:0]  mux_sel
);

  typedef enum logic [3:0] {
    ACC_IDLE  = 4'b0001,
    ACC_INIT  = 4'b0010,
    ACC_ELEM  = 4'b0100,
    ACC_QUANT = 4'b1000
  } acc_state_t;

  acc_state_t  state;
  logic [7:0]  conv_control;
  logic [7:0]  chain_stage_enable;
  logic [7:0]  rate_medium_gain_offset;
  logic [7:0]  coarse_and_fine_gain;
  logic [7:0]  fine_offset_select;
  logic [5:0]  mux_store;
  logic [1:0]  bandgap_mode;
  logic        start_pending;
  logic        load_defaults;
  logic        start_write;
  logic        repeat_mode;
  logic [2:0]  ratio_code;
  logic [1:0]  elementary_count_code;
  logic [2:0]  elem_idx;
  logic [10:0] period_cnt;
  logic [10:0] period_len;
  logic [2:0]  init_cnt;
  logic signed [17:0] accum;
  logic signed [17:0] mean;
  logic signed [31:0] scaled;
  logic        mod_meta;
  logic        mod_sync;
  logic        last_period;
  logic        last_elem;
  logic        seq_done;
  logic        begin_seq;

  acc_tick_if tick ();

  acc_tick_gen u_tick_gen (
    .clk_sys (clk_sys),
    .resetn  (resetn),
    .ce      (ce),
    .osc_in  (osc_in),
    .tick    (tick)
  );

  // ----------------------------------------------------------------
  // decode helpers
  // ----------------------------------------------------------------
  // medium gain value from its code
  function automatic logic [3:0] acc_medium_gain(input logic [1:0] code);
    case (code)
      2'h0:    acc_medium_gain = 4'h1;
      2'h1:    acc_medium_gain = 4'h2;
      2'h2:    acc_medium_gain = 4'h5;
      default: acc_medium_gain = 4'ha;
    endcase
  endfunction

  // signed count of 0.2 steps, magnitude capped at five
  function automatic logic [3:0] acc_medium_offset(input logic [3:0] code);
    logic [3:0] mag;
    mag = {1'b0, code[2:0]};
    if (mag > acc_pkg::MEDIUM_OFS_MAX) begin
      mag = acc_pkg::MEDIUM_OFS_MAX;
    end
    acc_medium_offset = code[3] ? (4'h0 - mag) : mag;
  endfunction

  // ----------------------------------------------------------------
  // write strobes
  // ----------------------------------------------------------------
  assign start_write   = reg_wr_en && reg_addr == acc_pkg::IDX_CONV_CONTROL &&
                         (reg_wdata[acc_pkg::START_BIT] || reg_wdata[acc_pkg::REPEAT_BIT]);
  assign load_defaults = reg_wr_en && reg_addr == acc_pkg::IDX_CONV_STATUS &&
                         reg_wdata[acc_pkg::LOAD_DEF_BIT];

  // ----------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------
  // start bit reads back zero; low bit is a test bit forced to zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      conv_control            <= acc_pkg::RST_CONV_CONTROL;
      chain_stage_enable      <= acc_pkg::RST_CHAIN_STAGE_EN;
      rate_medium_gain_offset <= acc_pkg::RST_RATE_MEDIUM;
      coarse_and_fine_gain    <= acc_pkg::RST_COARSE_FINE_GAIN;
      fine_offset_select      <= acc_pkg::RST_FINE_OFFSET;
      mux_store               <= acc_pkg::RST_MUX_SEL;
      bandgap_mode            <= acc_pkg::RST_BANDGAP_MODE;
    end else if (ce) begin
      if (load_defaults) begin
        conv_control            <= acc_pkg::RST_CONV_CONTROL;
        chain_stage_enable      <= acc_pkg::RST_CHAIN_STAGE_EN;
        rate_medium_gain_offset <= acc_pkg::RST_RATE_MEDIUM;
        coarse_and_fine_gain    <= acc_pkg::RST_COARSE_FINE_GAIN;
        fine_offset_select      <= acc_pkg::RST_FINE_OFFSET;
      end else if (reg_wr_en) begin
        case (reg_addr)
          acc_pkg::IDX_CONV_CONTROL:     conv_control <= {1'b0, reg_wdata[6:1], 1'b0};
          acc_pkg::IDX_CHAIN_STAGE_EN:   chain_stage_enable <= {4'h0, reg_wdata[3:0]};
          acc_pkg::IDX_RATE_MEDIUM:      rate_medium_gain_offset <= reg_wdata;
          acc_pkg::IDX_COARSE_FINE_GAIN: coarse_and_fine_gain <= reg_wdata;
          acc_pkg::IDX_FINE_OFFSET:      fine_offset_select <= {1'b0, reg_wdata[6:0]};
          acc_pkg::IDX_CONV_STATUS:      mux_store <= reg_wdata[5:0];
          acc_pkg::IDX_BANDGAP_MODE:     bandgap_mode <= reg_wdata[1:0];
          default: ;
        endcase
      end
    end
  end

  assign ratio_code            = conv_control[acc_pkg::RATIO_CODE_HI:acc_pkg::RATIO_CODE_LO];
  assign elementary_count_code = conv_control[acc_pkg::ELEM_CODE_HI:acc_pkg::ELEM_CODE_LO];
  assign repeat_mode           = conv_control[acc_pkg::REPEAT_BIT];

  // ----------------------------------------------------------------
  // read port
  // ----------------------------------------------------------------
  // registered read data; unmapped indices read zero
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      reg_rdata <= 8'h00;
    end else if (ce && reg_rd_en) begin
      case (reg_addr)
        acc_pkg::IDX_CONV_CONTROL:     reg_rdata <= conv_control;
        acc_pkg::IDX_CHAIN_STAGE_EN:   reg_rdata <= chain_stage_enable;
        acc_pkg::IDX_RATE_MEDIUM:      reg_rdata <= rate_medium_gain_offset;
        acc_pkg::IDX_COARSE_FINE_GAIN: reg_rdata <= coarse_and_fine_gain;
        acc_pkg::IDX_FINE_OFFSET:      reg_rdata <= fine_offset_select;
        acc_pkg::IDX_CONV_STATUS:      reg_rdata <= {busy, 1'b0, mux_store};
        acc_pkg::IDX_BANDGAP_MODE:     reg_rdata <= {6'h00, bandgap_mode};
        acc_pkg::IDX_RESULT_HI:        reg_rdata <= result[15:8];
        acc_pkg::IDX_RESULT_LO:        reg_rdata <= result[7:0];
        default:                       reg_rdata <= 8'h00;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // analog chain decode
  // ----------------------------------------------------------------
  // enable bits to blocks
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      modulator_on     <= 1'b0;
      coarse_amp_stage <= 1'b0;
      medium_amp_stage <= 1'b0;
      fine_amp_stage   <= 1'b0;
      coarse_bypass    <= 1'b1;
      medium_bypass    <= 1'b1;
      fine_bypass      <= 1'b1;
    end else if (ce) begin
      modulator_on     <= chain_stage_enable[acc_pkg::MOD_EN_BIT];
      coarse_amp_stage <= chain_stage_enable[acc_pkg::COARSE_EN_BIT];
      medium_amp_stage <= chain_stage_enable[acc_pkg::MEDIUM_EN_BIT];
      fine_amp_stage   <= chain_stage_enable[acc_pkg::FINE_EN_BIT];
      coarse_bypass    <= ~chain_stage_enable[acc_pkg::COARSE_EN_BIT];
      medium_bypass    <= ~chain_stage_enable[acc_pkg::MEDIUM_EN_BIT];
      fine_bypass      <= ~chain_stage_enable[acc_pkg::FINE_EN_BIT];
    end
  end

  // gains as plain values, offsets as signed step counts
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      coarse_gain_sel   <= 4'h1;
      medium_gain_sel   <= 4'h1;
      medium_offset_sel <= 4'h0;
      fine_gain_sel     <= 7'h00;
      fine_offset_sel   <= 7'h00;
      sample_rate_sel   <= 2'h0;
      mux_sel           <= 6'h00;
    end else if (ce) begin
      coarse_gain_sel   <= coarse_and_fine_gain[acc_pkg::COARSE_GAIN_BIT] ? 4'ha : 4'h1;
      medium_gain_sel   <= acc_medium_gain(
                             rate_medium_gain_offset[acc_pkg::MED_GAIN_HI:acc_pkg::MED_GAIN_LO]);
      medium_offset_sel <= acc_medium_offset(rate_medium_gain_offset[3:0]);
      fine_gain_sel     <= coarse_and_fine_gain[6:0];
      // sign and magnitude to two's complement
      fine_offset_sel   <= fine_offset_select[6] ? (7'h00 - {1'b0, fine_offset_select[5:0]})
                                                 : {1'b0, fine_offset_select[5:0]};
      sample_rate_sel   <= rate_medium_gain_offset[acc_pkg::RATE_SEL_HI:acc_pkg::RATE_SEL_LO];
      mux_sel           <= mux_store;
    end
  end

  // ----------------------------------------------------------------
  // sequencer
  // ----------------------------------------------------------------
  // modulator bit comes from the analog side, so synchronise it
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      mod_meta <= 1'b0;
      mod_sync <= 1'b0;
    end else if (ce) begin
      mod_meta <= mod_bit;
      mod_sync <= mod_meta;
    end
  end

  assign tick.rate_sel = rate_medium_gain_offset[acc_pkg::RATE_SEL_HI:acc_pkg::RATE_SEL_LO];
  assign tick.run      = (state == ACC_ELEM) || (state == ACC_QUANT);
  assign period_len    = (acc_pkg::RATIO_BASE << ratio_code) + 11'h001;
  assign last_period   = period_cnt == period_len - 11'h001;
  assign last_elem     = elem_idx == 3'((4'h1 << elementary_count_code) - 4'h1);
  assign seq_done      = (state == ACC_QUANT) && tick.fs_tick;
  assign busy          = state != ACC_IDLE;
  // start sources; pending start waits for the current sequence
  assign begin_seq     = load_defaults ||
                         ((state == ACC_IDLE) && (start_pending || start_write || start_in)) ||
                         (seq_done && (repeat_mode || start_pending || start_write || start_in));

  // clear beats set: a start arriving in the launch cycle does not stay pending
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      start_pending <= 1'b0;
    end else if (ce) begin
      if (begin_seq) begin
        start_pending <= busy && !seq_done && (start_write || start_in) && !load_defaults;
      end else if (start_write || start_in) begin
        start_pending <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      state      <= ACC_IDLE;
      init_cnt   <= 3'h0;
      period_cnt <= 11'h000;
      elem_idx   <= 3'h0;
    end else if (ce) begin
      if (begin_seq) begin
        state    <= ACC_INIT;
        init_cnt <= 3'h0;
      end else begin
        case (state)
          ACC_IDLE: state <= ACC_IDLE;
          ACC_INIT: begin
            init_cnt   <= init_cnt + 3'h1;
            period_cnt <= 11'h000;
            elem_idx   <= 3'h0;
            if (init_cnt == acc_pkg::INIT_CYCLES - 3'h1) begin
              state <= ACC_ELEM;
            end
          end
          ACC_ELEM: begin
            if (tick.fs_tick) begin
              period_cnt <= last_period ? 11'h000 : period_cnt + 11'h001;
              if (last_period) begin
                elem_idx <= elem_idx + 3'h1;
                if (last_elem) begin
                  state <= ACC_QUANT;
                end
              end
            end
          end
          ACC_QUANT: if (seq_done) state <= ACC_IDLE;
          default:   state <= ACC_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // accumulation and result
  // ----------------------------------------------------------------
  // polarity follows elementary parity
  assign amp_chop = elem_idx[0];

  // mean by shift, scaled to the 16 bit range
  assign mean   = accum >>> elementary_count_code;
  assign scaled = 32'(mean) <<< (4'hc - {1'b0, ratio_code});

  // digital sign undoes the analog chop so offset cancels in the sum
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      accum <= 18'sh00000;
    end else if (ce) begin
      if (state == ACC_INIT) begin
        accum <= 18'sh00000;
      end else if (state == ACC_ELEM && tick.fs_tick) begin
        accum <= (mod_sync ^ amp_chop) ? accum + 18'sh00001 : accum - 18'sh00001;
      end
    end
  end

  // store, pulse ready, busy drops with the state
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      result       <= 16'h0000;
      result_ready <= 1'b0;
    end else if (ce) begin
      result_ready <= seq_done;
      if (seq_done) begin
        if (scaled > 32'sh00007fff) begin
          result <= 16'h7fff;
        end else if (scaled < -32'sh00008000) begin
          result <= 16'h8000;
        end else begin
          result <= scaled[15:0];
        end
      end
    end
  end

  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      bandgap_chop <= 1'b1;
    end else if (ce) begin
      case (bandgap_mode)
        acc_pkg::BG_HIGH: bandgap_chop <= 1'b1;
        acc_pkg::BG_LOW:  bandgap_chop <= 1'b0;
        acc_pkg::BG_TOGGLE: begin
          if (state == ACC_ELEM && tick.fs_tick && last_period) begin
            bandgap_chop <= ~bandgap_chop;
          end
        end
        default: begin
          if (state == ACC_ELEM && tick.fs_tick && last_period && elem_idx[0]) begin
            bandgap_chop <= ~bandgap_chop;
          end
        end
      endcase
    end
  end

endmodule // acc_ctrl

`default_nettype wire

// ===== test/acc_osc_model.sv
/* far side: 4 MHz oscillator and a modulator held
   at one, a full-scale input. assumes ns units. */
`default_nettype none
module acc_osc_model (
  output var logic osc_in,
  output var logic mod_bit
);
  timeunit 1ns;
  timeprecision 1ps;
  // free running, no phase tie to clk_sys
  initial osc_in = 1'b0;
  initial mod_bit = 1'b1;
  always #125 osc_in = ~osc_in;
endmodule // acc_osc_model
`default_nettype wire

// ===== test/acc_ctrl_props.sv
/* checker on the ports of acc_ctrl.
   assumes one clock domain, clk_sys. */
`default_nettype none
module acc_ctrl_chk (
  input wire logic       clk_sys,
  input wire logic       resetn,
  input wire logic       ce,
  input wire logic       reg_wr_en,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic       busy,
  input wire logic       result_ready,
  input wire logic       modulator_on,
  input wire logic       coarse_bypass,
  input wire logic       medium_bypass,
  input wire logic       fine_bypass,
  input wire logic [3:0] coarse_gain_sel,
  input wire logic [3:0] medium_gain_sel,
  input wire logic [6:0] fine_gain_sel,
  input wire logic [6:0] fine_offset_sel,
  input wire logic       bandgap_chop,
  input wire logic [1:0] sample_rate_sel
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // write taken, one hot by index; a net so the assertions see sampled values
  logic [15:0] wr_hit;
  assign wr_hit = (ce && reg_wr_en) ? 16'h0001 << reg_addr : 16'h0000;
  // decodes lag the register a cycle
  chk_enable_decode: assert property (wr_hit[1] |-> ##2
    modulator_on == $past(reg_wdata[0], 2)) else $error("enable decode");
  chk_stage_bypass: assert property (wr_hit[1] |-> ##2
    {fine_bypass, medium_bypass, coarse_bypass} == ~$past(reg_wdata[3:1], 2))
    else $error("bypass decode");
  chk_coarse_gain: assert property (wr_hit[3] |-> ##2
    coarse_gain_sel == ($past(reg_wdata[7], 2) ? 4'ha : 4'h1)) else $error("coarse gain");
  // gain table 1, 2, 5, 10 packed as nibbles
  chk_medium_gain: assert property (wr_hit[2] |-> ##2
    medium_gain_sel == 4'(16'ha521 >> (4 * $past(reg_wdata[5:4], 2))))
    else $error("medium gain");
  chk_fine_gain: assert property (wr_hit[3] |-> ##2
    fine_gain_sel == $past(reg_wdata[6:0], 2)) else $error("fine gain");
  chk_fine_offset: assert property (wr_hit[4] |-> ##2
    fine_offset_sel == ($past(reg_wdata[6], 2) ? 7'h00 - 7'($past(reg_wdata[5:0], 2))
                                               : 7'($past(reg_wdata[5:0], 2))))
    else $error("fine offset");
  chk_bandgap_low: assert property (wr_hit[6] && reg_wdata[1:0] == 2'h1 |-> ##2
    !bandgap_chop) else $error("bandgap not low");
  chk_rate_sel: assert property (wr_hit[2] |-> ##2
    sample_rate_sel == $past(reg_wdata[7:6], 2)) else $error("rate select");
  chk_start_busy: assert property (wr_hit[0] && reg_wdata[7] |=> busy)
    else $error("start ignored");
  chk_busy_span: assert property ($rose(busy) |-> busy[*8])
    else $error("sequence too short");
  chk_ready_pulse: assert property (result_ready |=> !result_ready)
    else $error("ready too long");
  chk_ready_busy: assert property (result_ready |-> $past(busy))
    else $error("ready while idle");
endmodule // acc_ctrl_chk
bind acc_ctrl acc_ctrl_chk acc_ctrl_chk_i (.clk_sys(clk_sys), .resetn(resetn), .ce(ce),
  .reg_wr_en(reg_wr_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .busy(busy),
  .result_ready(result_ready), .modulator_on(modulator_on), .coarse_bypass(coarse_bypass),
  .medium_bypass(medium_bypass), .fine_bypass(fine_bypass),
  .coarse_gain_sel(coarse_gain_sel), .medium_gain_sel(medium_gain_sel),
  .fine_gain_sel(fine_gain_sel), .fine_offset_sel(fine_offset_sel),
  .bandgap_chop(bandgap_chop), .sample_rate_sel(sample_rate_sel));
`default_nettype wire

// ===== test/tb.sv
/* bench for acc_ctrl: register rows, offset decode,
   conversions. assumes acc_osc_model as far side. */
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys = 1'b0, resetn = 1'b0, ce = 1'b1;
  logic        reg_wr_en = 1'b0, reg_rd_en = 1'b0;
  logic [3:0]  reg_addr = 4'h0, medium_offset_sel, m;
  logic [7:0]  reg_wdata = 8'h00, reg_rdata;
  logic        osc_in, mod_bit, busy, result_ready, bandgap_chop;
  logic [15:0] result;
  int          num_errors = 0, num_checks = 0, i;
  // row three keeps fine stage on
  // index, byte written, byte read back; bandgap ends in half-rate mode
  logic [19:0] rows [10] = '{20'h00c0c, 20'h10e0e, 20'h1ff0f, 20'h2dddd,
    20'h38c8c, 20'h4ff7f, 20'h95500, 20'h51515, 20'h60101, 20'h60303};
  acc_ctrl acc_ctrl_i (.clk_sys(clk_sys), .resetn(resetn), .ce(ce), .reg_wr_en(reg_wr_en),
    .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .start_in(1'b0), .osc_in(osc_in), .mod_bit(mod_bit),
    .busy(busy), .result_ready(result_ready), .result(result), .modulator_on(),
    .coarse_amp_stage(), .medium_amp_stage(), .fine_amp_stage(), .coarse_bypass(),
    .medium_bypass(), .fine_bypass(), .coarse_gain_sel(), .medium_gain_sel(),
    .medium_offset_sel(medium_offset_sel), .fine_gain_sel(), .fine_offset_sel(),
    .amp_chop(), .bandgap_chop(bandgap_chop), .sample_rate_sel(), .mux_sel());
  acc_osc_model acc_osc_model_i (.osc_in(osc_in), .mod_bit(mod_bit));
  always #2 clk_sys = ~clk_sys;
  task automatic check(string n, logic [15:0] s, e);
    num_checks++;
    if (s !== e) begin
      num_errors++;
      $display("wrong value %s exp %h got %h", n, e, s);
    end
  endtask
  // one register cycle, strobe up for a single edge
  task automatic cyc(logic w, logic [3:0] a, logic [7:0] d);
    @(posedge clk_sys);
    reg_wr_en <= w;
    reg_rd_en <= !w;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk_sys);
    reg_wr_en <= 1'b0;
    reg_rd_en <= 1'b0;
    #1;
  endtask
  // a start while busy would wait, so let the chain go idle
  task automatic conv(logic [7:0] d, int n, logic [15:0] e);
    for (i = 0; i < 40000 && busy !== 1'b0; i++)
      @(negedge clk_sys);
    cyc(1'b1, acc_pkg::IDX_CONV_CONTROL, d);
    for (i = 0; i < 20000 && result_ready !== 1'b1; i++)
      @(negedge clk_sys);
    // (9n+1) ticks of 500 cycles, less up to 62 cycles of oscillator phase
    check("span", i > n * 4500 + 420 && i < n * 4500 + 530, 1'b1);
    check("result", result, e);
    check("busy at end", busy, 1'b0);
  endtask
  task automatic results;
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  // watchdog, about twice the expected run of 60 us
  initial begin
    #120us;
    num_errors++;
    results();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    for (int r = 0; r < 10; r++) begin
      cyc(1'b1, rows[r][19:16], rows[r][15:8]);
      cyc(1'b0, rows[r][19:16], 8'h00);
      check("readback", reg_rdata, rows[r][7:0]);
    end
    for (int c = 0; c < 16; c++) begin
      m = c[2:0] > 3'h5 ? 4'h5 : {1'b0, c[2:0]};
      cyc(1'b1, acc_pkg::IDX_RATE_MEDIUM, {2'h3, c[1:0], c[3:0]});
      @(posedge clk_sys);
      #1;
      check("medium offset", medium_offset_sel, 4'(c[3] ? -m : m));
    end
    // clock enable low: the write must not land
    @(posedge clk_sys);
    ce <= 1'b0;
    cyc(1'b1, acc_pkg::IDX_CHAIN_STAGE_EN, 8'h00);
    @(posedge clk_sys);
    ce <= 1'b1;
    cyc(1'b0, acc_pkg::IDX_CHAIN_STAGE_EN, 8'h00);
    check("frozen write", reg_rdata, 8'h0f);
    conv(8'h80, 1, 16'h7fff);
    check("bandgap one elem", bandgap_chop, 1'b0);
    conv(8'ha0, 2, 16'h0000);
    check("bandgap two elem", bandgap_chop, 1'b1);
    cyc(1'b1, acc_pkg::IDX_CONV_STATUS, 8'h40);
    cyc(1'b0, acc_pkg::IDX_CONV_CONTROL, 8'h00);
    check("defaults", reg_rdata, acc_pkg::RST_CONV_CONTROL);
    check("busy", busy, 1'b1);
    // reset in mid-run, while the defaults conversion is going
    @(posedge clk_sys);
    resetn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    #1;
    check("busy in reset", busy, 1'b0);
    @(posedge clk_sys);
    resetn <= 1'b1;
    cyc(1'b0, acc_pkg::IDX_CONV_STATUS, 8'h00);
    check("status after reset", reg_rdata, 8'h00);
    results();
  end
endmodule // tb
`default_nettype wire
